// *** core/charger_ctrl_irq_regs.v ***
// Functional notes
// - Bit 7 set stops watchdog timer
// - Bit 6 set disables charge safety timer
// - Bit 5 set enables power path
// - Bit 4 transceiver supply, reset 1, survives boost
// - Bit 2 picks pins or register limit
// - Bit 1 applies 4-bit input limit
// - Bit 0 enables automatic current adjustment
// - Control fields reset on all reset events; bit 4 not on boost entry
// - Temperature flags on bits 5 to 2
// - Bit 0 flags input within USB range
// - Input low flag from detect comparators
// - Input overvoltage flag on bit 3
// - Battery overvoltage flag on bit 1
// - Bit 0 summarises second interrupt register
// - Status summary from any status flag
// - Fault summary from charger or boost flags
// - Global mask blocks interrupt flags
`include "charger_regs_map.vh"
`timescale 1ns/1ns
`default_nettype none

module charger_ctrl_irq_regs #(
   parameter [6:0] DEVICE_ADDRESS = `DEVICE_ADDRESS
) (
   // Clock, reset, enable
   input  wire       clk,
   input  wire       arst_n,
   input  wire       ce,
   // Serial control bus
   input  wire       scl_in,
   input  wire       sda_in,
   output reg        sda_out,
   output reg        sda_oe_n,
   // Reset events and interrupt mask from the charger core
   input  wire       off_state,
   input  wire       reg_reset_cmd,
   input  wire       boost_mode_entry,
   input  wire       int_mask,
   // Neighbouring registers
   input  wire       second_charger_pending,
   input  wire       boost_pending,
   input  wire [3:0] input_limit_field,
   // Analog comparators and pins
   input  wire [3:0] temp_above,
   input  wire       vin_over_usb,
   input  wire       vin_under_usb,
   input  wire       vin_above_detect,
   input  wire       vin_charger_detect,
   input  wire       vin_over_lockout,
   input  wire       vbat_over,
   input  wire [1:0] limit_select_pins,
   // Control outputs
   output reg        watchdog_disable,
   output reg        charge_timer_disable,
   output reg        power_path_enable,
   output reg        transceiver_supply_enable,
   output reg        limit_source_select,
   output reg        input_limit_enable,
   output reg        auto_current_enable,
   output reg  [3:0] limit_code,
   // Summaries
   output reg        status_summary_bit,
   output reg        fault_summary_bit
);

   localparam [2:0] ST_IDLE    = 3'h0;
   localparam [2:0] ST_ADDR    = 3'h1;
   localparam [2:0] ST_ACK_AD  = 3'h2;
   localparam [2:0] ST_WRITE   = 3'h3;
   localparam [2:0] ST_ACK_WR  = 3'h4;
   localparam [2:0] ST_READ    = 3'h5;
   localparam [2:0] ST_ACK_RD  = 3'h6;

   // Synchronised pins
   wire [`SYNC_WIDTH-1:0] pins_sync;
   wire [1:0]             limit_pins_sync;
   wire                   scl_s;
   wire                   sda_s;
   wire [3:0]             temp_s       = pins_sync[9:6];
   wire                   usb_over_s   = pins_sync[5];
   wire                   usb_under_s  = pins_sync[4];
   wire                   detect_s     = pins_sync[3];
   wire                   chg_detect_s = pins_sync[2];
   wire                   lockout_s    = pins_sync[1];
   wire                   vbat_over_s  = pins_sync[0];

   sync_two #(.WIDTH(`SYNC_WIDTH)) u_sync_cmp (
      .clk      (clk),
      .arst_n   (arst_n),
      .ce       (ce),
      .async_in ({temp_above, vin_over_usb, vin_under_usb, vin_above_detect,
                  vin_charger_detect, vin_over_lockout, vbat_over}),
      .sync_out (pins_sync)
   );

   sync_two #(.WIDTH(4)) u_sync_bus (
      .clk      (clk),
      .arst_n   (arst_n),
      .ce       (ce),
      .async_in ({scl_in, sda_in, limit_select_pins}),
      .sync_out ({scl_s, sda_s, limit_pins_sync})
   );

   // Bus engine state
   reg [2:0] state;
   reg [2:0] bit_cnt;
   reg [7:0] shift;
   reg [7:0] tx;
   reg [7:0] pointer;
   reg       ptr_loaded, rw;
   reg       master_ack, byte_done;
   reg       scl_d, sda_d;
   reg       rd_clr_stat, rd_clr_ch1;

   wire scl_rise  = scl_s & ~scl_d;
   wire scl_fall  = ~scl_s & scl_d;
   wire start_cnd = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_cnd  = scl_s & scl_d & ~sda_d & sda_s;
   wire load_read = scl_fall & (((state == ST_ACK_AD) & rw) | ((state == ST_ACK_RD) & master_ack));
   wire wr_data   = scl_fall & (state == ST_WRITE) & byte_done & ptr_loaded;

   // Interrupt flags: 0-4 status register, 5-7 first charger register
   wire [7:0] flag_bits;
   wire       evt_common = off_state | reg_reset_cmd;
   wire       evt_boost  = evt_common | boost_mode_entry;
   wire [7:0] flag_cond  = {vbat_over_s,
                            lockout_s,
                            chg_detect_s & ~detect_s,
                            ~usb_under_s & ~usb_over_s,
                            temp_s};
   wire [7:0] flag_rd    = {{3{rd_clr_ch1}}, {5{rd_clr_stat}}};
   wire [7:0] flag_evt   = {{4{evt_boost}}, {4{evt_common}}};

   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_flag
         cor_flag u_flag (
            .clk         (clk),
            .arst_n      (arst_n),
            .ce          (ce),
            .cond        (flag_cond[i]),
            .arm         (~int_mask),
            .clear_read  (flag_rd[i]),
            .clear_event (flag_evt[i]),
            .flag        (flag_bits[i])
         );
      end
   endgenerate

   // Register images; unused bits read zero
   wire [7:0] ctrl_img = {watchdog_disable, charge_timer_disable, power_path_enable,
                          transceiver_supply_enable, 1'b0,
                          limit_source_select, input_limit_enable, auto_current_enable};
   wire [7:0] stat_img = {2'b00, flag_bits[3], flag_bits[2], flag_bits[1], flag_bits[0],
                          1'b0, flag_bits[4]};
   wire [7:0] ch1_img  = {3'b000, flag_bits[5], flag_bits[6], 1'b0, flag_bits[7],
                          second_charger_pending};

   // Read multiplexer
   function [7:0] read_value;
      input [7:0] addr;
      begin
         if (addr == `OFS_CONTROL_TWO) begin
            read_value = ctrl_img;
         end else if (addr == `OFS_STATUS_FLAGS) begin
            read_value = stat_img;
         end else if (addr == `OFS_CHARGER_FLAGS_ONE) begin
            read_value = ch1_img;
         end else begin
            read_value = 8'h00;
         end
      end
   endfunction
   wire [7:0] rd_byte = read_value(pointer);   // Byte a read would load now

   // Serial slave: start, stop, address, pointer, data
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state       <= ST_IDLE;
         bit_cnt     <= 3'h0;
         shift       <= 8'h00;
         tx          <= 8'h00;
         pointer     <= 8'h00;
         ptr_loaded  <= 1'b0;
         rw          <= 1'b0;
         master_ack  <= 1'b0;
         byte_done   <= 1'b0;
         scl_d       <= 1'b0;
         sda_d       <= 1'b0;
         sda_out     <= 1'b0;
         sda_oe_n    <= 1'b1;
         rd_clr_stat <= 1'b0;
         rd_clr_ch1  <= 1'b0;
      end else if (ce) begin
         scl_d       <= scl_s;
         sda_d       <= sda_s;
         sda_out     <= 1'b0;
         rd_clr_stat <= 1'b0;
         rd_clr_ch1  <= 1'b0;
         if (start_cnd) begin
            state      <= ST_ADDR;
            bit_cnt    <= 3'h0;
            byte_done  <= 1'b0;
            ptr_loaded <= 1'b0;
            sda_oe_n   <= 1'b1;
         end else if (stop_cnd) begin
            state    <= ST_IDLE;
            sda_oe_n <= 1'b1;
         end else if (load_read) begin
            // Fetch a byte; reading a flag register clears its flags
            tx          <= rd_byte;
            sda_oe_n    <= rd_byte[7];
            rd_clr_stat <= (pointer == `OFS_STATUS_FLAGS);
            rd_clr_ch1  <= (pointer == `OFS_CHARGER_FLAGS_ONE);
            pointer     <= pointer + 8'h01;
            bit_cnt     <= 3'h0;
            state       <= ST_READ;
         end else begin
            case (state)
               ST_ADDR, ST_WRITE: begin
                  if (scl_rise) begin
                     shift     <= {shift[6:0], sda_s};
                     bit_cnt   <= bit_cnt + 3'h1;
                     byte_done <= (bit_cnt == 3'h7);
                  end else if (scl_fall && byte_done) begin
                     byte_done <= 1'b0;
                     if (state == ST_ADDR) begin
                        if (shift[7:1] == DEVICE_ADDRESS) begin
                           rw       <= shift[0];
                           sda_oe_n <= 1'b0;
                           state    <= ST_ACK_AD;
                        end else begin
                           state <= ST_IDLE;
                        end
                     end else begin
                        if (!ptr_loaded) begin
                           pointer    <= shift;
                           ptr_loaded <= 1'b1;
                        end else begin
                           pointer <= pointer + 8'h01;
                        end
                        sda_oe_n <= 1'b0;
                        state    <= ST_ACK_WR;
                     end
                  end
               end
               ST_ACK_AD, ST_ACK_WR: begin
                  if (scl_fall) begin
                     sda_oe_n <= 1'b1;
                     bit_cnt  <= 3'h0;
                     state    <= ST_WRITE;
                  end
               end
               ST_READ: begin
                  if (scl_fall) begin
                     if (bit_cnt == 3'h7) begin
                        sda_oe_n <= 1'b1;
                        state    <= ST_ACK_RD;
                     end else begin
                        tx       <= {tx[6:0], 1'b0};
                        sda_oe_n <= tx[6];
                        bit_cnt  <= bit_cnt + 3'h1;
                     end
                  end
               end
               ST_ACK_RD: begin
                  if (scl_rise) begin
                     master_ack <= ~sda_s;
                  end else if (scl_fall) begin
                     state <= ST_IDLE;
                  end
               end
               default: begin
                  sda_oe_n <= 1'b1;
               end
            endcase
         end
      end
   end

   // Second control register
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         watchdog_disable          <= 1'b0;
         charge_timer_disable      <= 1'b0;
         power_path_enable         <= 1'b0;
         transceiver_supply_enable <= 1'b1;
         limit_source_select       <= 1'b1;
         input_limit_enable        <= 1'b1;
         auto_current_enable       <= 1'b0;
      end else if (ce) begin
         if (evt_boost) begin
            watchdog_disable     <= 1'b0;
            charge_timer_disable <= 1'b0;
            power_path_enable    <= 1'b0;
            limit_source_select  <= 1'b1;
            input_limit_enable   <= 1'b1;
            auto_current_enable  <= 1'b0;
         end else if (wr_data && (pointer == `OFS_CONTROL_TWO)) begin
            watchdog_disable     <= shift[`BIT_WATCHDOG_DISABLE];
            charge_timer_disable <= shift[`BIT_CHARGE_TIMER_DIS];
            power_path_enable    <= shift[`BIT_POWER_PATH];
            limit_source_select  <= shift[`BIT_LIMIT_SOURCE];
            input_limit_enable   <= shift[`BIT_LIMIT_ENABLE];
            auto_current_enable  <= shift[`BIT_AUTO_CURRENT];
         end
         if (evt_common) begin
            transceiver_supply_enable <= 1'b1;
         end else if (wr_data && (pointer == `OFS_CONTROL_TWO)) begin
            transceiver_supply_enable <= shift[`BIT_TRANSCEIVER_EN];
         end
      end
   end

   // Effective limit code and summaries
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         limit_code         <= 4'h0;
         status_summary_bit <= 1'b0;
         fault_summary_bit  <= 1'b0;
      end else if (ce) begin
         if (!input_limit_enable) begin
            limit_code <= 4'h0;
         end else if (limit_source_select) begin
            limit_code <= {2'b00, limit_pins_sync};
         end else begin
            limit_code <= input_limit_field;
         end
         status_summary_bit <= |flag_bits[4:0];
         fault_summary_bit  <= (|flag_bits[7:5]) | second_charger_pending | boost_pending;
      end
   end

endmodule

`default_nettype wire

// *** core/charger_regs_map.vh ***
`ifndef CHARGER_REGS_MAP_VH
`define CHARGER_REGS_MAP_VH

// Register offsets
`define OFS_CONTROL_TWO       8'h02
`define OFS_STATUS_FLAGS      8'h03
`define OFS_CHARGER_FLAGS_ONE 8'h04

// Second control register fields
`define BIT_WATCHDOG_DISABLE  7
`define BIT_CHARGE_TIMER_DIS  6
`define BIT_POWER_PATH        5
`define BIT_TRANSCEIVER_EN    4
`define BIT_LIMIT_SOURCE      2
`define BIT_LIMIT_ENABLE      1
`define BIT_AUTO_CURRENT      0
`define CONTROL_TWO_RESET     8'h16

// Status interrupt register fields
`define BIT_TEMP_WARNING      5
`define BIT_TEMP_FIRST        4
`define BIT_TEMP_SECOND       3
`define BIT_TEMP_SHUTDOWN     2
`define BIT_USB_RANGE         0

// First charger interrupt register fields
`define BIT_INPUT_LOW         4
`define BIT_INPUT_OVERVOLTAGE 3
`define BIT_BATTERY_OV        1
`define BIT_SECOND_SUMMARY    0

// Serial bus
`define DEVICE_ADDRESS        7'h2A
`define SYNC_WIDTH            10

`endif

// *** core/cor_flag.v ***
`timescale 1ns/1ns
`default_nettype none

module cor_flag (
   // Clock and reset
   input  wire clk,
   input  wire arst_n,
   input  wire ce,
   // Control
   input  wire cond,
   input  wire arm,
   input  wire clear_read,
   input  wire clear_event,
   // Flag
   output reg  flag
);

   // Reset event wins; a live condition beats a read clear
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flag <= 1'b0;
      end else if (ce) begin
         if (clear_event) begin
            flag <= 1'b0;
         end else if (arm && cond) begin
            flag <= 1'b1;
         end else if (clear_read) begin
            flag <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// *** core/sync_two.v ***
`timescale 1ns/1ns
`default_nettype none

module sync_two #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input  wire             clk,
   input  wire             arst_n,
   input  wire             ce,
   // Data
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] stage_one;

   // Two flip-flops; the first is read only by the second
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stage_one <= {WIDTH{1'b0}};
         sync_out  <= {WIDTH{1'b0}};
      end else if (ce) begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end

endmodule

`default_nettype wire

// *** tb/charger_ctrl_irq_regs_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module charger_ctrl_irq_regs_tb;
   logic       clk, arst_n, ce, scl, sda_out, sda_oe_n, int_mask, ack, ssum, fsum;
   wire logic  sda;
   logic [2:0] evt;
   logic [1:0] pend, pins;
   logic [3:0] field, temp, code;
   logic [5:0] cmp;
   logic [6:0] ctl;
   logic [7:0] rd;
   int         fails, checks, cyc;
   // Rows: control write, pins, field, expected limit code
   logic [17:0] rows [6] = '{{8'hFF, 2'h3, 4'hA, 4'h3}, {8'hE3, 2'h1, 4'h9, 4'h9}, {8'h25, 2'h2, 4'h7, 4'h0},
                             {8'h16, 2'h2, 4'h5, 4'h2}, {8'h02, 2'h0, 4'hC, 4'hC}, {8'hC9, 2'h3, 4'hF, 4'h0}};
   charger_ctrl_irq_regs #(.DEVICE_ADDRESS(7'h2A)) i_charger_ctrl_irq_regs (
      .clk(clk), .arst_n(arst_n), .ce(ce), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .off_state(evt[0]), .reg_reset_cmd(evt[1]), .boost_mode_entry(evt[2]),
      .int_mask(int_mask), .second_charger_pending(pend[1]), .boost_pending(pend[0]),
      .input_limit_field(field), .temp_above(temp), .vin_over_usb(cmp[5]), .vin_under_usb(cmp[4]),
      .vin_above_detect(cmp[3]), .vin_charger_detect(cmp[2]), .vin_over_lockout(cmp[1]),
      .vbat_over(cmp[0]), .limit_select_pins(pins), .watchdog_disable(ctl[6]),
      .charge_timer_disable(ctl[5]), .power_path_enable(ctl[4]), .transceiver_supply_enable(ctl[3]),
      .limit_source_select(ctl[2]), .input_limit_enable(ctl[1]), .auto_current_enable(ctl[0]),
      .limit_code(code), .status_summary_bit(ssum), .fault_summary_bit(fsum));
   serial_host i_serial_host (.clk(clk), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Hang guard, about three times the expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 50000) begin
         fails++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Read a register and compare with the expected byte
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      i_serial_host.read_reg(a, rd, ack);
      `CHK(rd, e)
      `CHK(ack, 1'b1)
   endtask
   // One-cycle reset event, then let it settle
   task automatic ev(input logic [2:0] e);
      @(negedge clk) evt = e;
      @(negedge clk) evt = 3'h0;
      wait_n(3);
   endtask
   // Main sequence
   initial begin
      logic [7:0] w;
      logic [3:0] e;
      arst_n = 1'b0;
      ce = 1'b1;
      evt = 3'h0;
      int_mask = 1'b1;
      pend = 2'h0;
      pins = 2'h0;
      field = 4'h0;
      temp = 4'h0;
      cmp = 6'h10;
      wait_n(16);
      arst_n = 1'b1;
      wait_n(4);
      `CHK(ctl, 7'h0E)
      rd_chk(8'h02, 8'h16);
      $display("test reset defaults done");
      for (int i = 0; i < 6; i++) begin
         {w, pins, field, e} = rows[i];
         i_serial_host.write_reg(8'h02, w, ack);
         wait_n(8);
         `CHK(ctl, {w[7:4], w[2:0]})
         `CHK(code, e)
         rd_chk(8'h02, w & 8'hF7);
      end
      $display("test control rows done");
      for (int k = 0; k < 3; k++) begin
         i_serial_host.write_reg(8'h02, 8'hE5, ack);
         ev(3'h1 << k);
         `CHK(ctl, (k == 2) ? 7'h06 : 7'h0E)
      end
      $display("test reset events done");
      temp = 4'hF;
      wait_n(6);
      temp = 4'h0;
      wait_n(6);
      rd_chk(8'h03, 8'h00);
      int_mask = 1'b0;
      temp = 4'hF;
      cmp = 6'h00;
      wait_n(6);
      temp = 4'h8;
      cmp = 6'h10;
      wait_n(6);
      `CHK(ssum, 1'b1)
      rd_chk(8'h03, 8'h3D);
      rd_chk(8'h03, 8'h20);
      temp = 4'h0;
      rd_chk(8'h03, 8'h20);
      rd_chk(8'h03, 8'h00);
      $display("test status flags done");
      cmp = 6'h17;
      pend = 2'h2;
      wait_n(6);
      cmp = 6'h1C;
      rd_chk(8'h04, 8'h1B);
      rd_chk(8'h04, 8'h01);
      `CHK(fsum, 1'b1)
      pend = 2'h1;
      wait_n(4);
      `CHK(fsum, 1'b1)
      pend = 2'h0;
      wait_n(4);
      `CHK(fsum, 1'b0)
      `CHK(ssum, 1'b0)
      $display("test charger flags done");
      rd_chk(8'h07, 8'h00);
      i_serial_host.write_reg(8'h03, 8'hFF, ack);
      rd_chk(8'h03, 8'h00);
      i_serial_host.dev = 7'h15;
      i_serial_host.write_reg(8'h02, 8'h00, ack);
      `CHK(ack, 1'b0)
      i_serial_host.dev = 7'h2A;
      `CHK(ctl, 7'h06)
      $display("test refusals done");
      // Reset command lost while frozen, then a mid-run reset
      ce = 1'b0;
      ev(3'h2);
      ce = 1'b1;
      wait_n(2);
      `CHK(ctl, 7'h06)
      arst_n = 1'b0;
      wait_n(2);
      arst_n = 1'b1;
      wait_n(4);
      `CHK(ctl, 7'h0E)
      rd_chk(8'h02, 8'h16);
      $display("test enable and reset done");
      give_verdict();
   end
endmodule
`default_nettype wire

// *** tb/charger_regs_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module charger_regs_props (
   // Clock and reset
   input wire logic       clk,
   input wire logic       arst_n,
   input wire logic       ce,
   // Events and sources
   input wire logic       off_state,
   input wire logic       reg_reset_cmd,
   input wire logic       boost_mode_entry,
   input wire logic       int_mask,
   input wire logic       boost_pending,
   input wire logic [3:0] input_limit_field,
   input wire logic [1:0] limit_select_pins,
   // Design outputs
   input wire logic       watchdog_disable,
   input wire logic       charge_timer_disable,
   input wire logic       power_path_enable,
   input wire logic       transceiver_supply_enable,
   input wire logic       limit_source_select,
   input wire logic       input_limit_enable,
   input wire logic       auto_current_enable,
   input wire logic [3:0] limit_code,
   input wire logic       status_summary_bit,
   input wire logic       fault_summary_bit
);
   default clocking @(posedge clk); endclocking
   // A frozen design is not judged
   default disable iff (!arst_n || !ce);
   // Control fields packed without the supply enable
   wire logic [5:0] ctl = {watchdog_disable, charge_timer_disable, power_path_enable,
                           limit_source_select, input_limit_enable, auto_current_enable};
   // Reset command and boost entry restore defaults, boost entry spares the supply enable
   a_reset_cmd_defaults: assert property (
      reg_reset_cmd |-> ##[1:2] (ctl == 6'h06 && transceiver_supply_enable))
      else $error("control defaults missing after reset command");
   a_boost_defaults: assert property (
      boost_mode_entry |-> ##[1:2] (ctl == 6'h06))
      else $error("control defaults missing after boost entry");
   a_boost_keeps_supply: assert property (
      boost_mode_entry && !reg_reset_cmd && !off_state |=> $stable(transceiver_supply_enable))
      else $error("supply enable changed on boost entry");
   // Limit code follows enable and source
   a_limit_off: assert property (
      (!input_limit_enable)[*3] |-> limit_code == 4'h0)
      else $error("limit code not zero while limit disabled");
   a_limit_from_field: assert property (
      (input_limit_enable && !limit_source_select && $stable(input_limit_field))[*3]
      |-> limit_code == input_limit_field)
      else $error("limit code does not follow register field");
   a_limit_from_pins: assert property (
      (input_limit_enable && limit_source_select && $stable(limit_select_pins))[*6]
      |-> limit_code == {2'h0, limit_select_pins})
      else $error("limit code does not follow pins");
   // Summaries
   a_mask_blocks_status: assert property (
      (int_mask && !status_summary_bit)[*2] ##1 int_mask |-> !status_summary_bit)
      else $error("status summary rose while masked");
   a_fault_from_boost: assert property (
      boost_pending[*2] |-> fault_summary_bit)
      else $error("fault summary missing for boost flag");
   // Main scenarios reached
   c_boost: cover property (boost_mode_entry);
   c_status: cover property ($rose(status_summary_bit));
   c_field: cover property (limit_code != 4'h0 && !limit_source_select);
endmodule
bind charger_ctrl_irq_regs charger_regs_props i_props (.clk, .arst_n, .ce, .off_state, .reg_reset_cmd,
   .boost_mode_entry, .int_mask, .boost_pending, .input_limit_field, .limit_select_pins,
   .watchdog_disable, .charge_timer_disable, .power_path_enable, .transceiver_supply_enable,
   .limit_source_select, .input_limit_enable, .auto_current_enable, .limit_code,
   .status_summary_bit, .fault_summary_bit);
`default_nettype wire

// *** tb/serial_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module serial_host (
   // Clock
   input  wire logic clk,
   // Bus pins
   input  wire logic sda_oe_n,
   output var  logic scl,
   output wire logic sda
);
   logic       drive;
   logic [6:0] dev;
   // Open-drain line with pull-up, low when either side pulls
   assign sda = drive & sda_oe_n;
   // Bus idles released
   initial begin
      scl = 1'b1;
      drive = 1'b1;
      dev = 7'h2A;
   end
   // Quarter of a bus clock period, well above the sync latency
   task automatic qtr();
      repeat (4) @(negedge clk);
   endtask
   // Start (a=1,b=0) or stop (a=0,b=1) condition
   task automatic cond(input logic a, input logic b);
      qtr();
      drive = a;
      qtr();
      scl = 1'b1;
      qtr();
      drive = b;
      qtr();
      scl = b;
   endtask
   // One bit; returns the line level late in the high phase
   task automatic clk_bit(input logic b, output logic got);
      qtr();
      drive = b;
      qtr();
      scl = 1'b1;
      qtr();
      qtr();
      got = sda;
      scl = 1'b0;
   endtask
   // Byte out MSB first, ack returned high when the device pulled low
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic g;
      for (int i = 7; i >= 0; i--) clk_bit(d[i], g);
      clk_bit(1'b1, g);
      ack = ~g;
   endtask
   // Byte in MSB first, closed by a NACK
   task automatic get_byte(output logic [7:0] d);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, g);
         d[i] = g;
      end
      clk_bit(1'b1, g);
   endtask
   task automatic write_reg(input logic [7:0] a, input logic [7:0] v, output logic ack);
      logic k0, k1, k2;
      cond(1'b1, 1'b0);
      put_byte({dev, 1'b0}, k0);
      put_byte(a, k1);
      put_byte(v, k2);
      cond(1'b0, 1'b1);
      ack = k0 & k1 & k2;
   endtask
   // Pointer write, repeated start, single byte read
   task automatic read_reg(input logic [7:0] a, output logic [7:0] v, output logic ack);
      logic k0, k1, k2;
      cond(1'b1, 1'b0);
      put_byte({dev, 1'b0}, k0);
      put_byte(a, k1);
      cond(1'b1, 1'b0);
      put_byte({dev, 1'b1}, k2);
      get_byte(v);
      cond(1'b0, 1'b1);
      ack = k0 & k1 & k2;
   endtask
endmodule
`default_nettype wire
